/* verilog/smr_supply_monitor_regulator_control.sv */
// supervision of the system supply, temperature and step-down regulator enables
//
// Contract
// RULE_01 - threshold code maps 2.3 V plus 0.1 V steps
// RULE_02 - threshold code resets to 0111, 3.0 V
// RULE_03 - status bit is one while supply below threshold
// RULE_04 - low condition holds until 200 mV recovery
// RULE_05 - mode one and unmasked: interrupt on undervoltage
// RULE_06 - interrupt clears after recovery and status read
// RULE_07 - mode zero: undervoltage shuts all regulators at once
// RULE_08 - overtemperature disables regulators, blocks re-enable
// RULE_09 - low battery output follows its comparator
// RULE_10 - enabled buck reference ramps over 400 us
// RULE_11 - select pin chooses primary or alternate code
// RULE_12 - processor writes the code selected by pin
// RULE_13 - buck regulates to default code after power-up
// RULE_14 - on bit acts on edges only
// RULE_15 - processor toggles on bit to enable or disable
// RULE_16 - interrupt pin pulled low while interrupt pending
// RULE_17 - asynchronous inputs pass two flip-flops first
`include "smr_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module smr_supply_monitor_regulator_control (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // analog comparator and pin inputs, asynchronous
    input wire logic supply_below_falling,
    input wire logic supply_above_rising,
    input wire logic overtemp_trip,
    input wire logic low_battery_input,
    input wire logic voltage_setting_select_pin,
    // control bits from the serial register file
    input wire logic [3:0] supply_threshold_wr_data,
    input wire logic supply_threshold_wr,
    input wire logic undervoltage_response_mode,
    input wire logic undervoltage_irq_unmask,
    input wire logic supply_low_status_rd,
    input wire smr_pkg::smr_buck_ctl_type buck_one_ctl,
    input wire smr_pkg::smr_buck_ctl_type buck_two_ctl,
    input wire smr_pkg::smr_buck_ctl_type buck_three_ctl,
    // threshold to the analog comparator
    output logic [3:0] supply_threshold_code,
    output logic [11:0] supply_threshold_mv,
    output logic [11:0] supply_rising_mv,
    // status
    output logic supply_low_status,
    output logic overtemp_active,
    output logic system_shutdown,
    // open-drain pins, enable low means pulled low
    output logic interrupt_request_out,
    output logic interrupt_request_oe_n,
    output logic low_battery_output,
    output logic low_battery_oe_n,
    // regulator controls
    output smr_pkg::smr_buck_stat_type buck_one_stat,
    output smr_pkg::smr_buck_stat_type buck_two_stat,
    output smr_pkg::smr_buck_stat_type buck_three_stat
);
    // synchroniser stages; first stage feeds only the second
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    wire [4:0] async_in = {voltage_setting_select_pin, low_battery_input, overtemp_trip,
                           supply_above_rising, supply_below_falling};
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
        end else begin
            sync1_reg <= async_in; // see RULE_17
            sync2_reg <= sync1_reg; // see RULE_17
        end
    end
    wire below_s = sync2_reg[0];
    wire above_rise_s = sync2_reg[1];
    wire overtemp_s = sync2_reg[2];
    wire lowbat_s = sync2_reg[3];
    wire voltage_setting_select_pin_s = sync2_reg[4];

    // threshold code register and its millivolt decode
    logic [3:0] thresh_reg;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            thresh_reg <= `SMR_THRESH_RESET; // see RULE_02
        else if (supply_threshold_wr)
            thresh_reg <= supply_threshold_wr_data;
    end
    assign supply_threshold_code = thresh_reg;
    wire [11:0] falling_mv = 12'(`SMR_THRESH_BASE_MV + thresh_reg * `SMR_THRESH_STEP_MV); // see RULE_01
    assign supply_threshold_mv = falling_mv;
    assign supply_rising_mv = 12'(falling_mv + `SMR_HYST_MV); // see RULE_04

    // low condition latches on falling trip, releases only above rising threshold
    logic low_reg;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            low_reg <= 1'b0;
        else if (below_s)
            low_reg <= 1'b1; // see RULE_04
        else if (above_rise_s)
            low_reg <= 1'b0; // see RULE_04
    end
    assign supply_low_status = low_reg; // see RULE_03

    // undervoltage interrupt state; a fresh drop wins over a pending clear
    smr_pkg::smr_uv_state_type uv_state_reg;
    smr_pkg::smr_uv_state_type uv_state_next;
    logic read_seen_reg;
    always_comb begin
        uv_state_next = uv_state_reg;
        case (uv_state_reg)
            smr_pkg::SMR_RUN: begin
                if (low_reg && undervoltage_response_mode && undervoltage_irq_unmask)
                    uv_state_next = smr_pkg::SMR_ALARM; // see RULE_05
            end
            smr_pkg::SMR_ALARM: begin
                if (!low_reg)
                    uv_state_next = smr_pkg::SMR_WAIT_READ;
            end
            smr_pkg::SMR_WAIT_READ: begin
                if (low_reg)
                    uv_state_next = smr_pkg::SMR_ALARM;
                else if (read_seen_reg || supply_low_status_rd)
                    uv_state_next = smr_pkg::SMR_RUN; // see RULE_06
            end
            default: uv_state_next = smr_pkg::SMR_RUN;
        endcase
    end
    // a read made while still low counts once the supply recovers
    wire read_seen_next = (uv_state_reg == smr_pkg::SMR_RUN) ? 1'b0 :
                          (read_seen_reg || supply_low_status_rd);
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            uv_state_reg <= smr_pkg::SMR_RUN;
            read_seen_reg <= 1'b0;
        end else begin
            uv_state_reg <= uv_state_next;
            read_seen_reg <= (uv_state_next == smr_pkg::SMR_RUN) ? 1'b0 : read_seen_next;
        end
    end
    wire irq_pending = (uv_state_reg != smr_pkg::SMR_RUN) && undervoltage_irq_unmask;

    // open-drain pins: drive low when active, release otherwise
    logic irq_oe_n_reg;
    logic lbo_oe_n_reg;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_oe_n_reg <= 1'b1;
            lbo_oe_n_reg <= 1'b1;
        end else begin
            irq_oe_n_reg <= !irq_pending; // see RULE_16
            lbo_oe_n_reg <= !lowbat_s; // see RULE_09
        end
    end
    assign interrupt_request_out = 1'b0;
    assign interrupt_request_oe_n = irq_oe_n_reg;
    assign low_battery_output = 1'b0;
    assign low_battery_oe_n = lbo_oe_n_reg;

    // global kill: undervoltage lockout in mode zero, or overtemperature
    wire uvlo_kill = low_reg && !undervoltage_response_mode; // see RULE_07
    wire kill = uvlo_kill || overtemp_s; // see RULE_08
    assign overtemp_active = overtemp_s;
    assign system_shutdown = kill;

    // per-regulator control gathered in arrays for the generate loop
    smr_pkg::smr_buck_ctl_type ctl_arr [`SMR_NUM_BUCK];
    smr_pkg::smr_buck_stat_type stat_arr [`SMR_NUM_BUCK];
    assign ctl_arr[0] = buck_one_ctl;
    assign ctl_arr[1] = buck_two_ctl;
    assign ctl_arr[2] = buck_three_ctl;
    assign buck_one_stat = stat_arr[0];
    assign buck_two_stat = stat_arr[1];
    assign buck_three_stat = stat_arr[2];

    genvar gi;
    generate
        for (gi = 0; gi < `SMR_NUM_BUCK; gi = gi + 1) begin : g_buck
            logic on_prev_reg;
            logic en_reg;
            logic [`SMR_RAMP_W-1:0] ramp_reg;
            logic [`SMR_VCODE_W-1:0] code_reg;
            logic booted_reg;
            // edges of the on bit; a steady level does nothing
            wire on_rise = ctl_arr[gi].on_bit && !on_prev_reg; // see RULE_14
            wire on_fall = !ctl_arr[gi].on_bit && on_prev_reg; // see RULE_14
            // re-enable is refused while the kill condition stands
            wire en_next = kill ? 1'b0 : (on_rise ? 1'b1 : (on_fall ? 1'b0 : en_reg)); // see RULE_08
            wire [`SMR_VCODE_W-1:0] sel_code = voltage_setting_select_pin_s ? ctl_arr[gi].alternate_voltage_code :
                                                 ctl_arr[gi].primary_voltage_code; // see RULE_11
            // soft-start counts up while enabled and restarts when disabled
            wire ramp_done = (ramp_reg == `SMR_RAMP_W'(`SMR_SOFTSTART_CYC));
            wire [`SMR_RAMP_W-1:0] ramp_next = !en_reg ? `SMR_RAMP_W'(0) :
                                   (ramp_done ? ramp_reg : `SMR_RAMP_W'(ramp_reg + 1'b1)); // see RULE_10
            always_ff @(posedge sys_clk or negedge nrst) begin
                if (!nrst) begin
                    on_prev_reg <= 1'b0;
                    en_reg <= 1'b0;
                    ramp_reg <= `SMR_RAMP_W'(0);
                    code_reg <= `SMR_VCODE_DEFAULT; // see RULE_13
                    booted_reg <= 1'b0;
                end else begin
                    on_prev_reg <= ctl_arr[gi].on_bit;
                    en_reg <= en_next;
                    ramp_reg <= ramp_next;
                    // default code stands until software first writes an on edge
                    booted_reg <= booted_reg || on_rise;
                    code_reg <= (booted_reg || on_rise) ? sel_code : `SMR_VCODE_DEFAULT; // see RULE_13
                end
            end
            // one driver per element; the code stays visible while off so the default shows
            assign stat_arr[gi] = '{enabled: en_reg, ramping: en_reg && !ramp_done,
                                    target_code: code_reg, ramp_level: ramp_reg}; // see RULE_13
        end
    endgenerate
endmodule : smr_supply_monitor_regulator_control
`default_nettype wire

/* verilog/smr_cfg.svh */
// timing counts, reset values and field constants for the supply monitor and regulator control
`ifndef SMR_CFG_SVH
`define SMR_CFG_SVH
`define SMR_THRESH_RESET 4'h0007
`define SMR_THRESH_BASE_MV 12'h08FC
`define SMR_THRESH_STEP_MV 12'h0064
`define SMR_HYST_MV 12'h00C8
`define SMR_CLK_MHZ 100
`define SMR_SOFTSTART_US 400
`define SMR_SOFTSTART_CYC (`SMR_SOFTSTART_US * `SMR_CLK_MHZ)
`define SMR_RAMP_W 16
`define SMR_NUM_BUCK 3
`define SMR_VCODE_W 6
`define SMR_VCODE_DEFAULT 6'h0018
`define SMR_ZERO_VCODE 6'h0000
`endif

/* verilog/smr_pkg.sv */
// types shared by the supply monitor and regulator control
package smr_pkg;
    typedef struct packed {
        logic [5:0] primary_voltage_code;
        logic [5:0] alternate_voltage_code;
        logic on_bit;
    } smr_buck_ctl_type;
    typedef struct packed {
        logic enabled;
        logic ramping;
        logic [5:0] target_code;
        logic [15:0] ramp_level;
    } smr_buck_stat_type;
    typedef enum logic [2:0] {
        SMR_RUN = 3'b001,
        SMR_ALARM = 3'b010,
        SMR_WAIT_READ = 3'b100
    } smr_uv_state_type;
endpackage : smr_pkg

/* tb/smr_host_model.sv */
// processor model: reads the status bit while the interrupt line is low
`timescale 1ns/1ns
`default_nettype none
module smr_host_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // interrupt line, read permission, read strobe
    input wire logic irq_line,
    input wire logic read_en,
    output logic status_rd
);
    // gap between strobes so each one is a separate read
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            status_rd <= 1'b0;
        end else begin
            status_rd <= read_en && !irq_line && !status_rd;
        end
    end
endmodule : smr_host_model
`default_nettype wire

/* tb/smr_asserts.sv */
// assertion checker for the supply monitor and regulator control
`timescale 1ns/1ns
`default_nettype none
module smr_chk (
    // clock, reset and watched ports
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic supply_below_falling,
    input wire logic supply_above_rising,
    input wire logic overtemp_trip,
    input wire logic undervoltage_response_mode,
    input wire logic undervoltage_irq_unmask,
    input wire smr_pkg::smr_buck_ctl_type buck_one_ctl,
    input wire logic [3:0] supply_threshold_code,
    input wire logic [11:0] supply_threshold_mv,
    input wire logic supply_low_status,
    input wire logic interrupt_request_oe_n,
    input wire smr_pkg::smr_buck_stat_type buck_one_stat
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // antecedents held long enough to cover the input synchronisers
    wire logic alarm = undervoltage_response_mode && undervoltage_irq_unmask && supply_below_falling;
    wire logic free = !overtemp_trip && (undervoltage_response_mode || !supply_low_status);
    sequence s_free; free [*4]; endsequence
    sequence s_on; !buck_one_ctl.on_bit ##1 buck_one_ctl.on_bit; endsequence
    property p_mv; supply_threshold_mv == 12'h08FC + 12'h0064 * supply_threshold_code; endproperty
    a_mv: assert property (p_mv) else $error("threshold mv wrong");
    property p_rst; $rose(nrst) |-> supply_threshold_code == 4'h7; endproperty
    a_rst: assert property (p_rst) else $error("reset code wrong");
    property p_stat; supply_below_falling [*4] |-> supply_low_status; endproperty
    a_stat: assert property (p_stat) else $error("status not set");
    property p_hold; (!supply_above_rising [*4]) ##0 supply_low_status |=> supply_low_status; endproperty
    a_hold: assert property (p_hold) else $error("status cleared early");
    property p_irq; alarm [*6] |-> !interrupt_request_oe_n; endproperty
    a_irq: assert property (p_irq) else $error("no interrupt");
    property p_shut; (!undervoltage_response_mode && supply_below_falling) [*6] |-> !buck_one_stat.enabled; endproperty
    a_shut: assert property (p_shut) else $error("no shutdown");
    property p_hot; overtemp_trip [*5] |-> !buck_one_stat.enabled; endproperty
    a_hot: assert property (p_hot) else $error("hot buck on");
    property p_on; s_free ##0 s_on |=> buck_one_stat.enabled && buck_one_stat.ramping; endproperty
    a_on: assert property (p_on) else $error("edge did not enable");
endmodule : smr_chk
`default_nettype wire

/* tb/smr_supply_monitor_regulator_control_test.sv */
// self-checking bench for the supply monitor and regulator control
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t mismatch", $time); end end
module smr_supply_monitor_regulator_control_test;
    logic sys_clk, nrst, supply_below_falling, supply_above_rising, overtemp_trip, rd_en, irq_line;
    logic low_battery_input, voltage_setting_select_pin, supply_threshold_wr, supply_low_status_rd;
    logic undervoltage_response_mode, undervoltage_irq_unmask, supply_low_status, low_battery_oe_n;
    logic interrupt_request_out, interrupt_request_oe_n;
    logic overtemp_active, system_shutdown, low_battery_output;
    logic [11:0] supply_rising_mv;
    logic [3:0] supply_threshold_wr_data, supply_threshold_code;
    logic [11:0] supply_threshold_mv;
    smr_pkg::smr_buck_ctl_type ctl;
    smr_pkg::smr_buck_stat_type buck_one_stat, buck_two_stat, buck_three_stat;
    int bad_count, cmp_count, n;
    // rows: code nibble beside expected millivolts
    logic [15:0] rows [4] = '{16'h08FC, 16'h7BB8, 16'hACE4, 16'hFED8};
    smr_supply_monitor_regulator_control i_dut (.*, .buck_one_ctl(ctl), .buck_two_ctl(ctl),
        .buck_three_ctl(ctl));
    smr_host_model i_host (.sys_clk(sys_clk), .nrst(nrst), .irq_line(irq_line),
        .read_en(rd_en), .status_rd(supply_low_status_rd));
    // pull-up on the open-drain interrupt line
    assign irq_line = interrupt_request_oe_n ? 1'b1 : interrupt_request_out;
    initial begin
        sys_clk = 0;
        forever #5 sys_clk = ~sys_clk;
    end
    // waits end at a falling edge so outputs have settled
    task automatic cyc(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : cyc
    task automatic turn_on();
        @(posedge sys_clk);
        ctl.on_bit <= 0;
        @(posedge sys_clk);
        ctl.on_bit <= 1;
        cyc(3);
    endtask : turn_on
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        {nrst, supply_below_falling, supply_above_rising, overtemp_trip, low_battery_input} = '0;
        {voltage_setting_select_pin, supply_threshold_wr, supply_threshold_wr_data, rd_en} = '0;
        {undervoltage_response_mode, undervoltage_irq_unmask} = '0;
        ctl = '{6'h05, 6'h2A, 1'b0};
        bad_count = 0;
        cmp_count = 0;
        cyc(2);
        @(posedge sys_clk);
        nrst <= 1;
        cyc(1);
        `CHK({supply_threshold_code, supply_low_status, irq_line, buck_one_stat.enabled}, 7'h3A)
        `CHK(buck_one_stat.target_code, 6'h18)
        foreach (rows[i]) begin
            @(posedge sys_clk);
            supply_threshold_wr <= 1;
            supply_threshold_wr_data <= rows[i][15:12];
            @(posedge sys_clk);
            supply_threshold_wr <= 0;
            cyc(2);
            `CHK({supply_threshold_code, supply_threshold_mv}, rows[i])
            `CHK(supply_rising_mv, rows[i][11:0] + 12'h00C8)
        end
        $display("reset and threshold table done");
        @(posedge sys_clk);
        low_battery_input <= 1;
        cyc(4);
        `CHK({low_battery_output, low_battery_oe_n}, 2'b00)
        @(posedge sys_clk);
        {undervoltage_response_mode, undervoltage_irq_unmask, supply_below_falling} <= 3'b111;
        cyc(7);
        `CHK({supply_low_status, irq_line}, 2'b10)
        @(posedge sys_clk);
        supply_below_falling <= 0;
        cyc(7);
        `CHK({supply_low_status, irq_line}, 2'b10)
        @(posedge sys_clk);
        supply_above_rising <= 1;
        cyc(7);
        `CHK({supply_low_status, irq_line}, 2'b00)
        @(posedge sys_clk);
        rd_en <= 1;
        cyc(7);
        `CHK(irq_line, 1'b1)
        $display("monitor and interrupt done");
        turn_on();
        `CHK({buck_one_stat.enabled, buck_two_stat.ramping, buck_three_stat.target_code}, 8'hC5)
        @(posedge sys_clk);
        voltage_setting_select_pin <= 1;
        cyc(4);
        `CHK(buck_two_stat.target_code, 6'h2A)
        for (n = 0; n < 40100 && buck_one_stat.ramping === 1'b1; n++) cyc(1);
        `CHK(n > 39980 && n < 40010, 1'b1)
        `CHK(buck_one_stat.ramp_level, 16'h9C40)
        if (n == 40100) tally_and_finish();
        @(posedge sys_clk);
        overtemp_trip <= 1;
        cyc(6);
        `CHK({buck_one_stat.enabled, buck_three_stat.enabled}, 2'b00)
        `CHK({overtemp_active, system_shutdown}, 2'b11)
        turn_on();
        `CHK(buck_two_stat.enabled, 1'b0)
        @(posedge sys_clk);
        overtemp_trip <= 0;
        cyc(5);
        `CHK(buck_one_stat.enabled, 1'b0)
        turn_on();
        `CHK(buck_one_stat.enabled, 1'b1)
        @(posedge sys_clk);
        {undervoltage_response_mode, supply_above_rising, supply_below_falling} <= 3'b001;
        cyc(7);
        `CHK({buck_one_stat.enabled, irq_line}, 2'b01)
        `CHK(system_shutdown, 1'b1)
        $display("regulator control done");
        tally_and_finish();
    end
endmodule : smr_supply_monitor_regulator_control_test
bind smr_supply_monitor_regulator_control smr_chk i_chk (.*);
`default_nettype wire
